//--- test/crx_exec_unit_tb_top.sv
// Self-checking bench for the call, return and rotate execution unit
`timescale 1ns/1ps
`include "crx_consts.svh"
module crx_exec_unit_tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic instrValid = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic [20:0] instrAddr = 21'h001000;
    logic extSetEn = 1'b0;
    logic [20:0] stackTop = 21'h0ABCD;
    logic [7:0] fileReadData = 8'h00;
    logic [7:0] callSaveAcc = 8'h3C;
    logic [7:0] callSaveFlags = 8'h01;
    logic [7:0] callSaveBank = 8'h03;
    logic shadowSave = 1'b0;
    logic intHighActive = 1'b0;
    logic stackPush, stackPop, pcLoad, fileRead, fileWrite;
    logic gieHighSet, gieLowSet, swResetReq, busy;
    logic [20:0] stackPushData, pcValue, pcV, pushV;
    logic [11:0] fileAddr, wA, rA;
    logic [7:0] fileWriteData, wD, accOut, flagsOut, bankOut, latchHighOut, latchUpperOut, expFlags;
    logic [15:0] ptr0Out, ptr1Out, ptr2Out, productOut;
    logic [1:0] ctxLevel;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int base = 0;
    int nPush, nPop, nPcl, nWr, nGh, nGl, nSr, nBusy;

    always #2 clk_sys = ~clk_sys;

    crx_exec_unit crx_exec_unit_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .instrValid(instrValid),
        .instrWord(instrWord), .instrAddr(instrAddr), .extSetEn(extSetEn), .stackTop(stackTop),
        .stackPush(stackPush), .stackPop(stackPop), .stackPushData(stackPushData), .pcLoad(pcLoad),
        .pcValue(pcValue), .fileAddr(fileAddr), .fileRead(fileRead), .fileReadData(fileReadData),
        .fileWrite(fileWrite), .fileWriteData(fileWriteData), .accOut(accOut), .flagsOut(flagsOut),
        .bankOut(bankOut), .ptr0Out(ptr0Out), .ptr1Out(ptr1Out), .ptr2Out(ptr2Out),
        .productOut(productOut), .latchHighOut(latchHighOut), .latchUpperOut(latchUpperOut),
        .callSaveAcc(callSaveAcc), .callSaveFlags(callSaveFlags), .callSaveBank(callSaveBank),
        .shadowSave(shadowSave), .intHighActive(intHighActive), .ctxLevel(ctxLevel),
        .gieHighSet(gieHighSet), .gieLowSet(gieLowSet), .swResetReq(swResetReq), .busy(busy));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Issues one instruction and records every pulse over a fixed window
    task automatic exec(input logic [15:0] w);
        instrWord = w;
        instrValid = 1'b1;
        {nPush, nPop, nPcl, nWr, nGh, nGl, nSr, nBusy} = '0;
        @(negedge clk_sys);
        instrValid = 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            if (busy === 1'b1) nBusy++;
            if (stackPush === 1'b1)
            begin
                nPush++;
                pushV = stackPushData;
            end
            if (stackPop === 1'b1) nPop++;
            if (pcLoad === 1'b1)
            begin
                nPcl++;
                pcV = pcValue;
            end
            if (fileRead === 1'b1) rA = fileAddr;
            if (fileWrite === 1'b1)
            begin
                nWr++;
                wD = fileWriteData;
                wA = fileAddr;
            end
            if (gieHighSet === 1'b1) nGh++;
            if (gieLowSet === 1'b1) nGl++;
            if (swResetReq === 1'b1) nSr++;
            @(negedge clk_sys);
        end
    endtask : exec

    function automatic logic [8:0] rot_model(input logic [5:0] op, input logic [7:0] v, input logic c);
        if (op == `CRX_OP_ROTATE_LEFT_CARRY_HI) return {v[7], v[6:0], c};
        if (op == `CRX_OP_ROTATE_LEFT_PLAIN_HI) return {c, v[6:0], v[7]};
        return {v[0], c, v[7:1]};
    endfunction : rot_model

    task automatic rot(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f,
        input logic [7:0] v, input logic [11:0] ea);
        logic [8:0] r;
        r = rot_model(op, v, expFlags[`CRX_BIT_C]);
        fileReadData = v;
        exec({op, d, a, f});
        if (base == 0) base = nBusy;
        if (op != `CRX_OP_ROTATE_LEFT_PLAIN_HI) expFlags[`CRX_BIT_C] = r[8];
        expFlags[`CRX_BIT_N] = r[7];
        expFlags[`CRX_BIT_Z] = (r[7:0] == 8'h00);
        chk(flagsOut, expFlags);
        chk(rA, ea);
        chk(nBusy, base);
        if (d)
        begin
            chk(nWr, 1);
            chk({wA, wD}, {ea, r[7:0]});
        end
        else
        begin
            chk(nWr, 0);
            chk(accOut, r[7:0]);
        end
    endtask : rot

    task automatic ret_chk(input logic [15:0] w, input logic [7:0] acc);
        exec(w);
        chk(nPop, 1);
        chk(pcV, stackTop);
        chk(accOut, acc);
        chk(nBusy, base + 4);
    endtask : ret_chk

    task automatic save(input logic hi);
        intHighActive = hi;
        shadowSave = 1'b1;
        @(negedge clk_sys);
        shadowSave = 1'b0;
        intHighActive = 1'b0;
    endtask : save

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        expFlags = 8'h00;
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        @(negedge clk_sys);
        rot(`CRX_OP_ROTATE_LEFT_PLAIN_HI, 1'b1, 1'b1, 8'h10, 8'hAB, 12'h010);
        $display("test rotate baseline done");
        exec(16'hDC00);
        chk(nPush, 1);
        chk(nPcl, 1);
        chk(pushV, 21'h001002);
        chk(pcV, 21'h000802);
        chk(nBusy, base + 4);
        exec(16'hDBFF);
        chk(pcV, 21'h001800);
        $display("test relative call done");
        ret_chk(16'h0013, 8'h3C);
        chk({bankOut, flagsOut}, 16'h0301);
        chk({latchUpperOut, latchHighOut}, 16'h0000);
        expFlags = 8'h01;
        {callSaveAcc, callSaveFlags, callSaveBank} = 24'h990099;
        ret_chk(16'h0012, 8'h3C);
        chk({bankOut, flagsOut}, 16'h0301);
        $display("test subroutine return done");
        rot(`CRX_OP_ROTATE_LEFT_CARRY_HI, 1'b0, 1'b0, 8'h20, 8'hE6, 12'h020);
        rot(`CRX_OP_ROTATE_LEFT_PLAIN_HI, 1'b1, 1'b1, 8'h10, 8'hAB, 12'h310);
        rot(`CRX_OP_ROTATE_RIGHT_CARRY_HI, 1'b0, 1'b0, 8'h90, 8'hE6, 12'hF90);
        extSetEn = 1'b1;
        rot(`CRX_OP_ROTATE_RIGHT_CARRY_HI, 1'b1, 1'b0, 8'h5F, 8'h01, 12'h05F);
        extSetEn = 1'b0;
        rot(`CRX_OP_ROTATE_LEFT_PLAIN_HI, 1'b0, 1'b0, 8'h40, 8'h80, 12'h040);
        $display("test rotates done");
        ret_chk(16'h0CA5, 8'hA5);
        chk({latchUpperOut, latchHighOut}, 16'h0000);
        exec(16'h0C5A);
        save(1'b0);
        exec(16'h0C77);
        save(1'b1);
        exec(16'h0C11);
        $display("test literal return done");
        ret_chk(16'h0011, 8'h77);
        chk(ctxLevel, 2'h1);
        chk(nGh, 1);
        chk(nGl, 0);
        chk({ptr0Out, ptr1Out}, 32'h0000_0000);
        chk({ptr2Out, productOut}, 32'h0000_0000);
        exec(16'h0C22);
        ret_chk(16'h0011, 8'h5A);
        chk(ctxLevel, 2'h0);
        chk(nGh, 0);
        chk(nGl, 1);
        exec(16'h0C22);
        ret_chk(16'h0010, 8'h22);
        chk(ctxLevel, 2'h1);
        $display("test interrupt return done");
        exec(16'h00FF);
        chk(nSr, 1);
        chk({ctxLevel, accOut}, 10'h000);
        chk(nBusy < base, 1);
        $display("test software reset done");
        give_verdict();
    end
endmodule : crx_exec_unit_tb_top

//--- verilog/crx_consts.svh
// Constants for the call, return and rotate execution block
`ifndef CRX_CONSTS_SVH
`define CRX_CONSTS_SVH
`define CRX_OP_RELATIVE_CALL_HI 5'h1B
`define CRX_OP_RESET 16'h00FF
`define CRX_OP_INTERRUPT_RETURN_HI 15'h0008
`define CRX_OP_RETURN_HI 15'h0009
`define CRX_OP_RETURN_WITH_LITERAL_HI 8'h0C
`define CRX_OP_ROTATE_LEFT_CARRY_HI 6'h0D
`define CRX_OP_ROTATE_LEFT_PLAIN_HI 6'h11
`define CRX_OP_ROTATE_RIGHT_CARRY_HI 6'h0C
`define CRX_PC_STEP 21'h000002
`define CRX_ILO_LIMIT 8'h5F
`define CRX_BIT_C 0
`define CRX_BIT_Z 2
`define CRX_BIT_N 4
`define CRX_Q1 2'h0
`define CRX_Q2 2'h1
`define CRX_Q4 2'h3
`define CRX_CTX_MAIN 2'h0
`define CRX_CTX_LOW 2'h1
`define CRX_CTX_HIGH 2'h2
`define CRX_CTX_IDLE 2'h3
`endif

//--- verilog/crx_exec_unit.sv
// Execution of call, reset, return and rotate instructions
`timescale 1ns/1ps
`include "crx_consts.svh"
module crx_exec_unit
    import crx_pkg::*;
#(
    parameter int PC_W = 21
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Instruction
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic [PC_W-1:0] instrAddr,
    input wire logic extSetEn,
    // Return stack
    input wire logic [PC_W-1:0] stackTop,
    output logic stackPush,
    output logic stackPop,
    output logic [PC_W-1:0] stackPushData,
    // Program counter
    output logic pcLoad,
    output logic [PC_W-1:0] pcValue,
    // Register file
    output logic [11:0] fileAddr,
    output logic fileRead,
    input wire logic [7:0] fileReadData,
    output logic fileWrite,
    output logic [7:0] fileWriteData,
    // Core registers
    output logic [7:0] accOut,
    output logic [7:0] flagsOut,
    output logic [7:0] bankOut,
    output logic [15:0] ptr0Out,
    output logic [15:0] ptr1Out,
    output logic [15:0] ptr2Out,
    output logic [15:0] productOut,
    output logic [7:0] latchHighOut,
    output logic [7:0] latchUpperOut,
    // Call save registers and shadow capture
    input wire logic [7:0] callSaveAcc,
    input wire logic [7:0] callSaveFlags,
    input wire logic [7:0] callSaveBank,
    input wire logic shadowSave,
    // Interrupt controller
    input wire logic intHighActive,
    output logic [1:0] ctxLevel,
    output logic gieHighSet,
    output logic gieLowSet,
    output logic swResetReq,
    output logic busy
);
    crx_state_t stateFf, nxt_state;
    logic [1:0] qFf;
    logic [15:0] opFf;
    logic [PC_W-1:0] addrFf;
    crx_ctx_t ctxFf;
    logic [1:0] ctxLevelFf;
    logic stackPushFf, stackPopFf, pcLoadFf, fileReadFf, fileWriteFf;
    logic [PC_W-1:0] stackPushDataFf, pcValueFf;
    logic [11:0] fileAddrFf;
    logic [7:0] fileWriteDataFf;
    logic gieHighFf, gieLowFf, swResetFf;
    logic busyFf;
    crx_shadow_if shd();

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire isRcall = (opFf[15:11] == `CRX_OP_RELATIVE_CALL_HI);
    wire isReset = (opFf == `CRX_OP_RESET);
    wire isRetfie = (opFf[15:1] == `CRX_OP_INTERRUPT_RETURN_HI);
    wire isReturn = (opFf[15:1] == `CRX_OP_RETURN_HI);
    wire isRetlw = (opFf[15:8] == `CRX_OP_RETURN_WITH_LITERAL_HI);
    wire isRlcf = (opFf[15:10] == `CRX_OP_ROTATE_LEFT_CARRY_HI);
    wire isRlncf = (opFf[15:10] == `CRX_OP_ROTATE_LEFT_PLAIN_HI);
    wire isRrcf = (opFf[15:10] == `CRX_OP_ROTATE_RIGHT_CARRY_HI);
    wire isRotate = isRlcf | isRlncf | isRrcf;
    wire restoreBit = opFf[0];
    wire destFile = opFf[9];
    wire accessBanked = opFf[8];
    wire [7:0] fOperand = opFf[7:0];
    wire isTwoCycle = isRcall | isRetfie | isReturn | isRetlw;
    wire [1:0] rotKind = isRlcf ? 2'h0 : (isRlncf ? 2'h1 : 2'h2);

    // Sign extended word offset doubled to a byte offset
    wire [PC_W-1:0] relOffset = {{(PC_W-12){opFf[10]}}, opFf[10:0], 1'b0};
    wire [PC_W-1:0] retAddr = addrFf + PC_W'(`CRX_PC_STEP);
    wire [PC_W-1:0] callTarget = retAddr + relOffset;

    // Banked, indexed or access bank addressing
    wire useIndexed = !accessBanked && extSetEn && (fOperand <= `CRX_ILO_LIMIT);
    wire [11:0] idxAddr = ctxFf.ptr2[11:0] + {4'h0, fOperand};
    wire [11:0] accessAddr = fOperand[7] ? {4'hF, fOperand} : {4'h0, fOperand};
    wire [11:0] rotAddr = useIndexed ? idxAddr : (accessBanked ? {ctxFf.bank[3:0], fOperand} : accessAddr);

    logic [7:0] rotRes;
    logic rotCarry, rotCarryUsed;
    crx_rotator u_rot
    (
        .src(fileReadData),
        .carryIn(ctxFf.flags[`CRX_BIT_C]),
        .kind(rotKind),
        .res(rotRes),
        .carryOut(rotCarry),
        .carryUsed(rotCarryUsed)
    );

    // Shadow set follows the context the core runs in
    wire shadowSel = (ctxLevelFf == `CRX_CTX_LOW);
    assign shd.readSel = shadowSel;
    assign shd.saveEn = shadowSave;
    assign shd.saveSel = intHighActive ? 1'b0 : 1'b1;
    assign shd.saveData = ctxFf;
    crx_shadow_store u_shadow
    (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .shd(shd)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    wire lastQ = (qFf == `CRX_Q4);
    always_comb
    begin
        nxt_state = stateFf;
        unique case (stateFf)
            CRX_FETCH: if (instrValid) nxt_state = CRX_EXEC;
            CRX_EXEC:
                if (isReset && qFf == `CRX_Q1)
                    nxt_state = CRX_RESET;
                else if (lastQ)
                    nxt_state = isTwoCycle ? CRX_IDLE2 : CRX_FETCH;
            CRX_IDLE2: if (lastQ) nxt_state = CRX_FETCH;
            CRX_RESET: nxt_state = CRX_FETCH;
        endcase
    end

    wire inExec = (stateFf == CRX_EXEC);
    wire execQ4 = inExec && lastQ;
    wire rotQ2 = inExec && isRotate && (qFf == `CRX_Q2);
    wire rotQ4 = execQ4 && isRotate;
    wire [7:0] newFlagsRot = {ctxFf.flags[7:5], rotRes[7], ctxFf.flags[3], (rotRes == 8'h00),
                              ctxFf.flags[1], rotCarryUsed ? rotCarry : ctxFf.flags[`CRX_BIT_C]};

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stateFf <= CRX_FETCH;
            qFf <= `CRX_Q1;
            opFf <= 16'h0000;
            addrFf <= '0;
            busyFf <= 1'b0;
        end
        else if (stateFf == CRX_RESET)
        begin
            stateFf <= nxt_state;
            qFf <= `CRX_Q1;
            opFf <= 16'h0000;
            busyFf <= 1'b0;
        end
        else
        begin
            stateFf <= nxt_state;
            busyFf <= (nxt_state != CRX_FETCH);
            qFf <= (stateFf == CRX_FETCH) ? `CRX_Q1 : qFf + 2'h1;
            if (stateFf == CRX_FETCH && instrValid)
            begin
                opFf <= instrWord;
                addrFf <= instrAddr;
            end
        end
    end

    // ----------------------------------------
    // Architectural registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctxFf <= '0;
            ctxLevelFf <= `CRX_CTX_MAIN;
        end
        else if (stateFf == CRX_RESET)
        begin
            ctxFf <= '0;
            ctxLevelFf <= `CRX_CTX_MAIN;
        end
        else if (execQ4)
        begin
            if (isRetfie)
            begin
                ctxLevelFf <= shadowSel ? `CRX_CTX_MAIN : `CRX_CTX_LOW;
                if (restoreBit)
                    ctxFf <= shd.readData;
            end
            if (isRetlw)
                ctxFf.acc <= opFf[7:0];
            if (isReturn && restoreBit)
            begin
                ctxFf.acc <= callSaveAcc;
                ctxFf.flags <= callSaveFlags;
                ctxFf.bank <= callSaveBank;
            end
            if (isRotate)
            begin
                ctxFf.flags <= newFlagsRot;
                if (!destFile)
                    ctxFf.acc <= rotRes;
            end
        end
        else if (shadowSave)
            ctxLevelFf <= intHighActive ? `CRX_CTX_HIGH : `CRX_CTX_LOW;
    end

    // ----------------------------------------
    // Pulsed outputs
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stackPushFf <= 1'b0;
            stackPopFf <= 1'b0;
            stackPushDataFf <= '0;
            pcLoadFf <= 1'b0;
            pcValueFf <= '0;
            fileReadFf <= 1'b0;
            fileWriteFf <= 1'b0;
            fileAddrFf <= 12'h000;
            fileWriteDataFf <= 8'h00;
            gieHighFf <= 1'b0;
            gieLowFf <= 1'b0;
            swResetFf <= 1'b0;
        end
        else
        begin
            stackPushFf <= execQ4 && isRcall;
            stackPushDataFf <= retAddr;
            stackPopFf <= execQ4 && (isRetfie || isReturn || isRetlw);
            pcLoadFf <= execQ4 && (isRcall || isRetfie || isReturn || isRetlw);
            pcValueFf <= isRcall ? callTarget : stackTop;
            fileReadFf <= rotQ2;
            fileWriteFf <= rotQ4 && destFile;
            fileAddrFf <= rotAddr;
            fileWriteDataFf <= rotRes;
            gieHighFf <= execQ4 && isRetfie && !shadowSel;
            gieLowFf <= execQ4 && isRetfie && shadowSel;
            swResetFf <= (stateFf == CRX_RESET);
        end
    end

    assign stackPush = stackPushFf;
    assign stackPop = stackPopFf;
    assign stackPushData = stackPushDataFf;
    assign pcLoad = pcLoadFf;
    assign pcValue = pcValueFf;
    assign fileRead = fileReadFf;
    assign fileWrite = fileWriteFf;
    assign fileAddr = fileAddrFf;
    assign fileWriteData = fileWriteDataFf;
    assign accOut = ctxFf.acc;
    assign flagsOut = ctxFf.flags;
    assign bankOut = ctxFf.bank;
    assign ptr0Out = ctxFf.ptr0;
    assign ptr1Out = ctxFf.ptr1;
    assign ptr2Out = ctxFf.ptr2;
    assign productOut = {ctxFf.prodHigh, ctxFf.prodLow};
    assign latchHighOut = ctxFf.latchHigh;
    assign latchUpperOut = ctxFf.latchUpper;
    assign ctxLevel = ctxLevelFf;
    assign gieHighSet = gieHighFf;
    assign gieLowSet = gieLowFf;
    assign swResetReq = swResetFf;
    assign busy = busyFf;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_call_push_jump: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (execQ4 && isRcall) |=> (stackPush && pcLoad && pcValue == $past(callTarget)))
        else $error("relative call push or jump wrong");
    chk_call_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (execQ4 && isRcall) |=> (stateFf == CRX_IDLE2)[*4])
        else $error("relative call second cycle not idle");
    chk_reset_q2: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (inExec && isReset && qFf == `CRX_Q1) |=> ##1 swResetReq)
        else $error("software reset not started");
    chk_interrupt_return_pop: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (execQ4 && isRetfie) |=> (stackPop && pcLoad && (gieHighSet || gieLowSet)))
        else $error("interrupt return pop or enable missing");
    chk_interrupt_return_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (execQ4 && isRetfie && !restoreBit) |=> (ctxFf == $past(ctxFf)))
        else $error("registers changed without restore");
    chk_return_with_literal_acc: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (execQ4 && isRetlw) |=> (accOut == $past(opFf[7:0]) && latchHighOut == $past(latchHighOut)))
        else $error("literal return accumulator wrong");
    chk_return_save: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (execQ4 && isReturn && restoreBit) |=> (accOut == $past(callSaveAcc) && bankOut == $past(callSaveBank)))
        else $error("call save not restored");
    chk_rlnc_carry: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (execQ4 && isRlncf) |=> (flagsOut[`CRX_BIT_C] == $past(flagsOut[`CRX_BIT_C])))
        else $error("plain rotate touched carry");
    chk_rot_dest: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (rotQ4 && destFile) |=> (fileWrite && fileWriteData == $past(rotRes)))
        else $error("rotate register write missing");
    chk_rot_one_cycle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (execQ4 && isRotate) |=> (stateFf == CRX_FETCH))
        else $error("rotate took more than one cycle");
    chk_rot_read_q2: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rotQ2 |=> (fileRead && fileAddr == $past(rotAddr)))
        else $error("rotate operand read missing");
    chk_reset_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (stateFf == CRX_RESET) |=> (accOut == 8'h00 && flagsOut == 8'h00 && ctxLevel == `CRX_CTX_MAIN))
        else $error("software reset left state");
    chk_interrupt_return_gie_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (execQ4 && isRetfie) |=> !(gieHighSet && gieLowSet))
        else $error("both priority enables set");
    chk_interrupt_return_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (execQ4 && isRetfie) |=> (ctxLevel != $past(ctxLevel)))
        else $error("context level not updated");
endmodule : crx_exec_unit

//--- verilog/crx_pkg.sv
// Types shared by the call, return and rotate execution block
package crx_pkg;
    typedef enum logic [3:0]
    {
        CRX_FETCH = 4'h1,
        CRX_EXEC = 4'h2,
        CRX_IDLE2 = 4'h4,
        CRX_RESET = 4'h8
    } crx_state_t;
    typedef struct packed
    {
        logic [7:0] acc;
        logic [7:0] flags;
        logic [7:0] bank;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [15:0] ptr2;
        logic [7:0] prodLow;
        logic [7:0] prodHigh;
        logic [7:0] latchHigh;
        logic [7:0] latchUpper;
    } crx_ctx_t;
endpackage : crx_pkg

//--- verilog/crx_rotator.sv
// Rotate unit for the three byte rotates
`timescale 1ns/1ps
module crx_rotator
(
    // Operand
    input wire logic [7:0] src,
    input wire logic carryIn,
    input wire logic [1:0] kind,
    // Result
    output logic [7:0] res,
    output logic carryOut,
    output logic carryUsed
);
    // kind 0: left through carry, 1: left plain, 2: right through carry
    assign res = (kind == 2'h0) ? {src[6:0], carryIn} :
                 (kind == 2'h1) ? {src[6:0], src[7]} : {carryIn, src[7:1]};
    assign carryOut = (kind == 2'h2) ? src[0] : src[7];
    assign carryUsed = (kind != 2'h1);
endmodule : crx_rotator

//--- verilog/crx_shadow_if.sv
// Interface carrying the shadow sets between core and shadow store
`timescale 1ns/1ps
interface crx_shadow_if;
    import crx_pkg::*;
    logic saveEn;
    logic saveSel;
    crx_ctx_t saveData;
    logic readSel;
    crx_ctx_t readData;
    modport core (output saveEn, output saveSel, output saveData, output readSel, input readData);
    modport store (input saveEn, input saveSel, input saveData, input readSel, output readData);
endinterface : crx_shadow_if

//--- verilog/crx_shadow_store.sv
// Two shadow context sets: high and low
`timescale 1ns/1ps
module crx_shadow_store
    import crx_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Shadow access
    crx_shadow_if.store shd
);
    crx_ctx_t setFf [2];
    crx_ctx_t readFf;

    // Store one set per interrupt context (high and low), read registered
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            setFf[0] <= '0;
            setFf[1] <= '0;
            readFf <= '0;
        end
        else
        begin
            if (shd.saveEn)
                setFf[shd.saveSel] <= shd.saveData;
            readFf <= setFf[shd.readSel];
        end
    end

    assign shd.readData = readFf;
endmodule : crx_shadow_store
